// file: hdl/rhw_counters.sv
// rhw_counters: hour and day-of-week stages of the real-time clock.
// assumes hour_carry_i is a one-cycle pulse from the minute stage
// and a register master that never waits.
`timescale 1ns/10ps
`default_nettype none
module rhw_counters
	import rhw_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       hour_carry_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rd_data_o,
	output logic            day_carry_o,
	output logic            week_carry_o,
	output logic            update_in_progress_o
);

	// ************************************************************
	// control register
	// ************************************************************
	logic       run_reg;
	logic       fmt24_reg;
	logic       afternoon_flag_reg;
	logic       pm_toggle;
	logic       ctrl_wr;

	assign ctrl_wr = wr_i && (addr_i == CLOCK_CTRL_OFS);

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			run_reg   <= 1'b0;
			fmt24_reg <= 1'b0;
		end else if (ctrl_wr) begin
			run_reg   <= wr_data_i[RUN_BIT];
			fmt24_reg <= wr_data_i[FMT24_BIT];
		end
	end

	// the hardware toggle wins over a software write in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			afternoon_flag_reg <= 1'b0;
		end else if (pm_toggle) begin
			afternoon_flag_reg <= !afternoon_flag_reg;
		end else if (ctrl_wr) begin
			afternoon_flag_reg <= wr_data_i[PM_BIT];
		end
	end

	// ************************************************************
	// update sequencing
	// ************************************************************
	// the carry is held for a busy window before it is applied so that
	// software sampling the busy bit sees it ahead of the change
	rhw_update_state_t state_reg;
	logic [1:0]        busy_cnt_reg;
	logic              pending_reg;
	logic              apply;

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pending_reg <= 1'b0;
		end else if (hour_carry_i && run_reg) begin
			pending_reg <= 1'b1;
		end else if (state_reg == RHW_APPLY) begin
			pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state_reg    <= RHW_IDLE;
			busy_cnt_reg <= 2'h0;
		end else begin
			case (state_reg)
				RHW_IDLE: begin
					if (pending_reg && run_reg) begin
						state_reg    <= RHW_BUSY;
						busy_cnt_reg <= 2'(UPDATE_BUSY_CYCLES - 1);
					end
				end
				RHW_BUSY: begin
					if (busy_cnt_reg == 2'h0) begin
						state_reg <= RHW_APPLY;
					end else begin
						busy_cnt_reg <= busy_cnt_reg - 2'h1;
					end
				end
				RHW_APPLY: begin
					state_reg <= RHW_IDLE;
				end
				default: begin
					state_reg <= RHW_IDLE;
				end
			endcase
		end
	end

	assign apply                = (state_reg == RHW_APPLY);
	assign update_in_progress_o = (state_reg != RHW_IDLE) || pending_reg;

	// ************************************************************
	// counting stages
	// ************************************************************
	logic [1:0] hour_tens;
	logic [3:0] hour_units;
	logic [2:0] weekday;
	logic       day_carry;
	logic       hour_wrap;
	logic       week_carry;
	logic       hour_wr;
	logic       weekday_wr;

	assign hour_wr    = wr_i && (addr_i == HOUR_COUNT_OFS);
	assign weekday_wr = wr_i && (addr_i == WEEKDAY_COUNT_OFS);

	rhw_hour_stage u_hour (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.carry_i     (apply),
		.fmt24_i     (fmt24_reg),
		.wr_i        (hour_wr),
		.wr_data_i   (wr_data_i[5:0]),
		.tens_o      (hour_tens),
		.units_o     (hour_units),
		.day_carry_o (hour_wrap),
		.pm_toggle_o (pm_toggle)
	);

	rhw_weekday_stage u_weekday (
		.sys_clk_i    (sys_clk_i),
		.nrst_i       (nrst_i),
		.carry_i      (day_carry),
		.wr_i         (weekday_wr),
		.wr_data_i    (wr_data_i[2:0]),
		.weekday_o    (weekday),
		.week_carry_o (week_carry)
	);

	// in 12-hour form the hour wraps twice a day; only the wrap that
	// leaves the afternoon ends the day, so the weekday moves once a day
	assign day_carry    = hour_wrap && (fmt24_reg || afternoon_flag_reg);
	assign day_carry_o  = day_carry;
	assign week_carry_o = week_carry;

	// ************************************************************
	// read port
	// ************************************************************
	function automatic logic [7:0] read_mux(input logic [3:0] a);
		case (a)
			HOUR_COUNT_OFS:    read_mux = {update_in_progress_o, 1'b0, hour_tens, hour_units};
			WEEKDAY_COUNT_OFS: read_mux = {update_in_progress_o, 4'h0, weekday};
			CLOCK_CTRL_OFS:    read_mux = {run_reg, fmt24_reg, afternoon_flag_reg, 5'h00};
			default:           read_mux = 8'h00;
		endcase
	endfunction : read_mux

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_i) begin
			rd_data_o <= read_mux(addr_i);
		end else begin
			rd_data_o <= 8'h00;
		end
	end

endmodule : rhw_counters
`default_nettype wire

// file: hdl/rhw_hour_stage.sv
// rhw_hour_stage: bcd hour counter with 12/24 range and day carry.
// assumes carry_i is a one-cycle pulse on sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
module rhw_hour_stage
	import rhw_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       carry_i,
	input  wire logic       fmt24_i,
	input  wire logic       wr_i,
	input  wire logic [5:0] wr_data_i,
	output logic      [1:0] tens_o,
	output logic      [3:0] units_o,
	output logic            day_carry_o,
	output logic            pm_toggle_o
);
	logic [1:0] tens_reg;
	logic [3:0] units_reg;
	logic [7:0] top;

	assign top         = fmt24_i ? HOUR_TOP_24 : HOUR_TOP_12;
	assign day_carry_o = carry_i && ({2'h0, tens_reg, units_reg} == top);
	// in 12-hour form each wrap flips morning and afternoon
	assign pm_toggle_o = day_carry_o && !fmt24_i;
	assign tens_o      = tens_reg;
	assign units_o     = units_reg;

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			tens_reg  <= HOUR_TENS_RST;
			units_reg <= HOUR_UNITS_RST;
		end else if (wr_i) begin
			tens_reg  <= wr_data_i[5:4];
			units_reg <= wr_data_i[3:0];
		end else if (carry_i) begin
			if (day_carry_o) begin
				tens_reg  <= HOUR_TENS_RST;
				units_reg <= HOUR_UNITS_RST;
			end else if (units_reg == BCD_UNITS_LAST) begin
				units_reg <= HOUR_UNITS_RST;
				tens_reg  <= tens_reg + 2'h1;
			end else begin
				units_reg <= units_reg + 4'h1;
			end
		end
	end
endmodule : rhw_hour_stage
`default_nettype wire

// file: hdl/rhw_pkg.sv
// rhw_pkg: constants shared by the hour and weekday counting stages.
// assumes a single 10 MHz system clock and a plain register port.
package rhw_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [3:0] HOUR_COUNT_OFS    = 4'h0;
	localparam logic [3:0] WEEKDAY_COUNT_OFS = 4'h1;
	localparam logic [3:0] CLOCK_CTRL_OFS    = 4'h2;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int UIP_BIT     = 7;
	localparam int RUN_BIT     = 7;
	localparam int FMT24_BIT   = 6;
	localparam int PM_BIT      = 5;

	// ************************************************************
	// values after reset and count limits
	// ************************************************************
	localparam logic [1:0] HOUR_TENS_RST   = 2'h0;
	localparam logic [3:0] HOUR_UNITS_RST  = 4'h0;
	localparam logic [2:0] WEEKDAY_RST     = 3'h0;
	localparam logic [2:0] WEEKDAY_LAST    = 3'h6;
	localparam logic [7:0] HOUR_TOP_12     = 8'h11;
	localparam logic [7:0] HOUR_TOP_24     = 8'h23;
	localparam logic [3:0] BCD_UNITS_LAST  = 4'h9;
	// cycles spent in RHW_BUSY before each counter update is applied
	localparam int UPDATE_BUSY_CYCLES      = 2;

	typedef enum logic [1:0] {
		RHW_IDLE,
		RHW_BUSY,
		RHW_APPLY
	} rhw_update_state_t;

endpackage : rhw_pkg

// file: hdl/rhw_weekday_stage.sv
// rhw_weekday_stage: binary day-of-week counter, sunday is zero.
// assumes carry_i is a one-cycle pulse on sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
module rhw_weekday_stage
	import rhw_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       carry_i,
	input  wire logic       wr_i,
	input  wire logic [2:0] wr_data_i,
	output logic      [2:0] weekday_o,
	output logic            week_carry_o
);
	logic [2:0] weekday_reg;

	assign weekday_o    = weekday_reg;
	assign week_carry_o = carry_i && (weekday_reg >= WEEKDAY_LAST);

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			weekday_reg <= WEEKDAY_RST;
		end else if (wr_i) begin
			weekday_reg <= wr_data_i;
		end else if (carry_i) begin
			// a stray reserved code also wraps to sunday
			if (weekday_reg >= WEEKDAY_LAST) begin
				weekday_reg <= WEEKDAY_RST;
			end else begin
				weekday_reg <= weekday_reg + 3'h1;
			end
		end
	end
endmodule : rhw_weekday_stage
`default_nettype wire

// file: sim/rhw_counters_bench.sv
// rhw_counters_bench: self-checking bench for the hour and weekday counters.
// assumes rhw_pkg and the design are compiled first.
`timescale 1ns/10ps
`default_nettype none
module rhw_counters_bench import rhw_pkg::*;;
	// ****************
	// stimulus and checks
	// ****************
	logic       clk = 1'b0, nrst = 1'b0, carry = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdat = 8'h00, rdat, h, top;
	logic       dayc, weekc, busy, f24, pm;
	logic [2:0] wk;
	int         fails = 0, check_count = 0, cyc = 0, seed = 51;
	int         days = 0, wks = 0, ed = 0, ew = 0, i, n, v;
	rhw_counters uut (.sys_clk_i(clk), .nrst_i(nrst), .hour_carry_i(carry), .addr_i(addr),
		.wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .day_carry_o(dayc),
		.week_carry_o(weekc), .update_in_progress_o(busy));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		days <= days + (dayc === 1'b1);
		wks <= wks + (weekc === 1'b1);
		// whole run needs under a thousand cycles
		if (cyc == 20000) begin
			fails = fails + 1;
			test_done();
		end
	end
	task automatic test_done;
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(nm, e, rdat);
	endtask : rreg
	task automatic tick(input logic run);
		@(posedge clk);
		carry <= 1'b1;
		@(posedge clk);
		carry <= 1'b0;
		#1 chk("busy", {7'h0, run}, {7'h0, busy});
		for (n = 0; n < 10 && busy !== 1'b0; n++) @(posedge clk) #1;
		chk("busy clear", 8'h00, {7'h0, busy});
	endtask : tick
	function automatic logic [7:0] hnext(input logic [7:0] x, input logic [7:0] t);
		if (x == t) return 8'h00;
		if (x[3:0] == BCD_UNITS_LAST) return {x[7:4] + 4'h1, 4'h0};
		return x + 8'h01;
	endfunction : hnext
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rreg(HOUR_COUNT_OFS, 8'h00, "hour rst");
		rreg(WEEKDAY_COUNT_OFS, 8'h00, "wk rst");
		rreg(CLOCK_CTRL_OFS, 8'h00, "ctrl rst");
		wreg(HOUR_COUNT_OFS, 8'hd2);
		rreg(HOUR_COUNT_OFS, 8'h12, "hour rsvd");
		wreg(WEEKDAY_COUNT_OFS, 8'hfd);
		rreg(WEEKDAY_COUNT_OFS, 8'h05, "wk rsvd");
		wreg(4'hf, 8'h5a);
		rreg(4'hf, 8'h00, "unmapped");
		tick(1'b0);
		rreg(HOUR_COUNT_OFS, 8'h12, "hold");
		// first eight passes sit at the units carry or at the day and week wrap, morning and afternoon
		for (i = 0; i < 16; i++) begin
			f24 = i[0];
			top = f24 ? HOUR_TOP_24 : HOUR_TOP_12;
			v = $unsigned($random(seed)) % (f24 ? 24 : 12);
			h = (i < 8) ? (i[1] ? top : 8'h09) : 8'((v / 10) * 16 + v % 10);
			wk = (i < 8) ? WEEKDAY_LAST : 3'($unsigned($random(seed)) % 7);
			pm = (i < 8) ? i[2] : 1'($unsigned($random(seed)) % 2);
			wreg(CLOCK_CTRL_OFS, {1'b1, f24, pm, 5'h00});
			wreg(HOUR_COUNT_OFS, h);
			wreg(WEEKDAY_COUNT_OFS, {5'h0, wk});
			repeat (3) begin
				tick(1'b1);
				// a 12-hour wrap ends the day only when it leaves the afternoon
				if (h == top && (f24 || pm)) begin
					ed++;
					ew += (wk == WEEKDAY_LAST);
					wk = (wk == WEEKDAY_LAST) ? 3'h0 : wk + 3'h1;
				end
				if (h == top) begin
					pm ^= !f24;
				end
				h = hnext(h, top);
				rreg(HOUR_COUNT_OFS, h, "hour");
				rreg(WEEKDAY_COUNT_OFS, {5'h0, wk}, "weekday");
				rreg(CLOCK_CTRL_OFS, {1'b1, f24, pm, 5'h0}, "ctrl");
			end
		end
		chk("day carries", 8'(ed), 8'(days));
		chk("week carries", 8'(ew), 8'(wks));
		// a second reset in mid-run must clear counts and control again
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		rreg(HOUR_COUNT_OFS, 8'h00, "hour rst2");
		rreg(WEEKDAY_COUNT_OFS, 8'h00, "wk rst2");
		rreg(CLOCK_CTRL_OFS, 8'h00, "ctrl rst2");
		test_done();
	end
endmodule : rhw_counters_bench
bind rhw_counters rhw_counters_props chk_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
	.hour_carry_i(hour_carry_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .day_carry_o(day_carry_o), .week_carry_o(week_carry_o),
	.update_in_progress_o(update_in_progress_o));
`default_nettype wire

// file: sim/rhw_counters_props.sv
// rhw_counters_props: port-level checks of the hour and weekday counters.
// assumes it is bound onto rhw_counters and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module rhw_counters_props
	import rhw_pkg::*;
(
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic       hour_carry_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic       day_carry_o,
	input wire logic       week_carry_o,
	input wire logic       update_in_progress_o
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic rh = rd_i && addr_i == HOUR_COUNT_OFS;
	wire logic rw = rd_i && addr_i == WEEKDAY_COUNT_OFS;
	AST_BUSY_CAUSE: assert property ($rose(update_in_progress_o) |-> $past(hour_carry_i))
		else $error("busy rose without carry");
	AST_BUSY_END: assert property ($rose(update_in_progress_o) |-> ##[1:6] !update_in_progress_o)
		else $error("busy stuck");
	AST_BUSY_LEN: assert property ($rose(update_in_progress_o) |-> update_in_progress_o[*4] ##1 !update_in_progress_o)
		else $error("busy window length wrong");
	AST_BUSY_READ: assert property ((rh || rw) |=> rd_data_o[UIP_BIT] == $past(update_in_progress_o))
		else $error("busy bit wrong in read");
	AST_HOUR_RSVD: assert property (rh |=> !rd_data_o[6])
		else $error("hour bit 6 set");
	AST_HOUR_BCD: assert property (rh |=> rd_data_o[5:4] <= 2'h2 && rd_data_o[3:0] <= BCD_UNITS_LAST)
		else $error("hour not bcd");
	AST_WK_RSVD: assert property (rw |=> rd_data_o[6:3] == 4'h0)
		else $error("weekday reserved bits set");
	AST_WK_RANGE: assert property (rw |=> rd_data_o[2:0] <= WEEKDAY_LAST)
		else $error("weekday out of range");
	AST_WEEK_CARRY: assert property (week_carry_o |-> day_carry_o)
		else $error("week carry without day carry");
	AST_DAY_CARRY: assert property (day_carry_o |-> update_in_progress_o && !$past(day_carry_o))
		else $error("day carry outside update");
endmodule : rhw_counters_props
`default_nettype wire
